// >>> inc/slave_guard_regs.svh
`ifndef SLAVE_GUARD_REGS_SVH
`define SLAVE_GUARD_REGS_SVH

// ==========================================================================
// Register offsets
`define REG_UNLOCK_ADDR 16'h0020
`define REG_GUARD_ADDR 16'h0021
`define DEV_UNLOCK_ADDR 16'h0030
`define DEV_GUARD_ADDR 16'h0031
`define DATA_LINK_CTRL0_ADDR 16'h0100
`define DATA_LINK_CTRL1_ADDR 16'h0101
`define DATA_LINK_CTRL2_ADDR 16'h0102
`define DATA_LINK_CTRL3_ADDR 16'h0103

// ==========================================================================
// Guarded address areas of the register-level protection
`define GUARD_A_HI 16'h0137
`define GUARD_B_LO 16'h013a
`define GUARD_B_HI 16'h0f0f

// ==========================================================================
// Field positions and reset values
`define GUARD_BIT 0
`define FWD_RULE_BIT 0
`define TEMP_USE_BIT 1
`define GUARD_RESET 1'b0
`define DATA_LINK_CTRL0_RESET 2'h0
`define LOOP_CFG_RESET 8'h00
`define MAC_LOCAL_MASK 48'h0000_0000_0002

// ==========================================================================
// Timing
`define CLK_KHZ 10000
`define TEMP_HOLD_MS 1000

`endif

// >>> inc/slave_guard_pkg.sv
package slave_guard_pkg;

    // Two-bit loop field codes, in field order 00, 01, 10, 11.
    typedef enum logic [1:0] {
        LOOP_AUTO,
        LOOP_AUTO_CLOSE,
        LOOP_OPEN,
        LOOP_CLOSED
    } loop_code_t;

endpackage

// >>> rtl/loop_port.sv
`timescale 1ns/1ns
`default_nettype none

module loop_port
    import slave_guard_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire loop_code_t code_i,
    input wire logic code_written_i,
    input wire logic link_pin_i,
    input wire logic busy_i,
    input wire logic valid_rx_i,
    output logic loop_closed_o,
    output logic port_enable_o
);

    // ======================================================================
    // Link pin synchroniser
    logic sync1, sync2, sync3, link_up, next_link_up;
    logic hold, next_hold, closed, next_closed, target;

    always_comb begin
        next_link_up = (sync2 == sync3) ? sync2 : link_up;
    end

    // ======================================================================
    // Loop decision
    always_comb begin
        next_hold = hold;
        // The write strobe arrives only when this port's field is rewritten with auto close.
        // R13: auto close latch
        if (!link_up) begin
            next_hold = 1'b1;
        end else if (valid_rx_i || code_written_i) begin
            next_hold = 1'b0;
        end
        unique case (code_i)
            // R12: follow link state
            LOOP_AUTO: target = !link_up;
            LOOP_AUTO_CLOSE: target = hold;
            // R14: forced codes
            LOOP_OPEN: target = 1'b0;
            LOOP_CLOSED: target = 1'b1;
        endcase
        // R15: defer while busy
        next_closed = busy_i ? closed : target;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            link_up <= 1'b0;
            hold <= 1'b1;
            closed <= 1'b0;
        end else begin
            sync1 <= link_pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
            link_up <= next_link_up;
            hold <= next_hold;
            closed <= next_closed;
        end
    end

    // R11: closed port stops traffic
    assign loop_closed_o = closed;
    assign port_enable_o = !closed;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    forced_closed_a: assert property (code_i == LOOP_CLOSED && !busy_i |=> loop_closed_o) // R14
        else $error("Forced closed code did not close the loop.");
    forced_open_a: assert property (code_i == LOOP_OPEN && !busy_i |=> port_enable_o) // R14
        else $error("Forced open code did not open the loop.");
    busy_defer_a: assert property (busy_i |=> $stable(loop_closed_o)) // R15
        else $error("Loop changed during a frame.");
    auto_follow_a: assert property (code_i == LOOP_AUTO && !busy_i |=> loop_closed_o == !$past(link_up)) // R12
        else $error("Auto loop did not follow link.");

endmodule

`default_nettype wire

// >>> rtl/slave_write_guard.sv
// Notes on behaviour
// R1: Register guard refuses protected writes until the frame writes the unlock byte.
// R2: Register unlock lasts one frame only.
// R3: Register guard bit protects the two areas; the device unlock byte stays writable.
// R4: Device guard refuses all writes until the frame writes the device unlock byte.
// R5: Device unlock lasts one frame only.
// R6: Device guard bit protects everything except the device unlock byte.
// R7: Rule zero processes native frames and passes others without processing them.
// R8: Rule one processes native frames and destroys all others.
// R9: Every passed frame gets the locally administered sender bit set.
// R10: Temporary bit makes loop writes revert after about one second.
// R11: Open loop enables a port; closed loop bypasses it internally.
// R12: Auto code closes on link down and opens on link up.
// R13: Auto close reopens only on rewrite after link up or valid frame.
// R14: Codes 10 and 11 force open or closed regardless of link.
// R15: Loop changes wait until the current port frame ends.
// R16: Local interface reads only; its writes change nothing.
`timescale 1ns/1ns
`default_nettype none
`include "slave_guard_regs.svh"

module slave_write_guard
    import slave_guard_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter int TEMP_CYCLES = `TEMP_HOLD_MS * `CLK_KHZ
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic frm_start_i,
    input wire logic frm_end_i,
    input wire logic frm_native_i,
    input wire logic [47:0] frm_sender_addr_i,
    output logic frm_process_o,
    output logic frm_forward_o,
    output logic frm_drop_o,
    output logic [47:0] frm_sender_addr_o,
    input wire logic net_wr_i,
    input wire logic net_rd_i,
    input wire logic [15:0] net_addr_i,
    input wire logic [7:0] net_wdata_i,
    output logic net_wr_accept_o,
    output logic [7:0] net_rdata_o,
    input wire logic local_rd_i,
    input wire logic local_wr_i,
    input wire logic [15:0] local_addr_i,
    output logic [7:0] local_rdata_o,
    output logic local_wr_ignored_o,
    input wire logic [NUM_PORTS-1:0] link_up_i,
    input wire logic [NUM_PORTS-1:0] port_busy_i,
    input wire logic [NUM_PORTS-1:0] valid_rx_i,
    output logic [NUM_PORTS-1:0] loop_closed_o,
    output logic [NUM_PORTS-1:0] port_enable_o,
    output logic temp_active_o
);

    if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 4.");
    end
    if (TEMP_CYCLES < 1 || TEMP_CYCLES >= 2 ** 24) begin : g_bad_temp
        $error("TEMP_CYCLES out of range.");
    end

    // ======================================================================
    // State
    logic reg_guard, dev_guard, reg_unlock_val, dev_unlock_val;
    logic reg_unlocked, dev_unlocked;
    logic [1:0] data_link_ctrl0;
    logic [7:0] loop_cfg, saved_cfg;
    logic temp_active;
    logic [23:0] temp_timer;
    logic next_reg_guard, next_dev_guard, next_reg_unlock_val, next_dev_unlock_val;
    logic next_reg_unlocked, next_dev_unlocked;
    logic [1:0] next_data_link_ctrl0;
    logic [7:0] next_loop_cfg, next_saved_cfg;
    logic next_temp_active;
    logic [23:0] next_temp_timer;
    logic in_area, reg_block, dev_block, accept, frame_edge;

    function automatic logic [7:0] read_byte(input logic [15:0] addr);
        unique case (addr)
            `REG_UNLOCK_ADDR: read_byte = {7'h00, reg_unlock_val};
            `REG_GUARD_ADDR: read_byte = {7'h00, reg_guard};
            `DEV_UNLOCK_ADDR: read_byte = {7'h00, dev_unlock_val};
            `DEV_GUARD_ADDR: read_byte = {7'h00, dev_guard};
            `DATA_LINK_CTRL0_ADDR: read_byte = {6'h00, data_link_ctrl0};
            `DATA_LINK_CTRL1_ADDR: read_byte = loop_cfg;
            default: read_byte = 8'h00;
        endcase
    endfunction

    // ======================================================================
    // Write protection
    always_comb begin
        in_area = (net_addr_i <= `GUARD_A_HI)
            || (net_addr_i >= `GUARD_B_LO && net_addr_i <= `GUARD_B_HI);
        // The unlock byte is exempt too, or no frame could ever lift the guard.
        // R3: register area guard
        reg_block = reg_guard && !reg_unlocked && in_area
            && net_addr_i != `REG_UNLOCK_ADDR && net_addr_i != `DEV_UNLOCK_ADDR;
        // R6: whole device guard
        dev_block = dev_guard && !dev_unlocked && net_addr_i != `DEV_UNLOCK_ADDR;
        // R1: refuse unless unlocked
        accept = net_wr_i && !reg_block && !dev_block;
        frame_edge = frm_start_i || frm_end_i;
    end

    assign net_wr_accept_o = accept;

    always_comb begin
        next_reg_guard = reg_guard;
        next_dev_guard = dev_guard;
        next_reg_unlock_val = reg_unlock_val;
        next_dev_unlock_val = dev_unlock_val;
        // R2: unlock ends with the frame
        next_reg_unlocked = frame_edge ? 1'b0 : reg_unlocked;
        // R5: unlock ends with the frame
        next_dev_unlocked = frame_edge ? 1'b0 : dev_unlocked;
        next_data_link_ctrl0 = data_link_ctrl0;
        next_loop_cfg = loop_cfg;
        next_saved_cfg = saved_cfg;
        next_temp_active = temp_active;
        next_temp_timer = temp_timer;
        // R10: revert after the hold time
        if (temp_active) begin
            if (temp_timer == 24'h000000) begin
                next_loop_cfg = saved_cfg;
                next_temp_active = 1'b0;
            end else begin
                next_temp_timer = temp_timer - 24'h000001;
            end
        end
        // R16: only the network side writes
        if (accept) begin
            unique case (net_addr_i)
                `REG_UNLOCK_ADDR: begin
                    next_reg_unlock_val = net_wdata_i[`GUARD_BIT];
                    // R1: any value unlocks
                    next_reg_unlocked = !frm_end_i;
                end
                `DEV_UNLOCK_ADDR: begin
                    next_dev_unlock_val = net_wdata_i[`GUARD_BIT];
                    // R4: any value unlocks
                    next_dev_unlocked = !frm_end_i;
                end
                `REG_GUARD_ADDR: next_reg_guard = net_wdata_i[`GUARD_BIT];
                `DEV_GUARD_ADDR: next_dev_guard = net_wdata_i[`GUARD_BIT];
                `DATA_LINK_CTRL0_ADDR: next_data_link_ctrl0 = net_wdata_i[1:0];
                `DATA_LINK_CTRL1_ADDR: begin
                    next_loop_cfg = net_wdata_i;
                    // R10: temporary or permanent use
                    if (data_link_ctrl0[`TEMP_USE_BIT]) begin
                        if (!temp_active) begin
                            next_saved_cfg = loop_cfg;
                        end
                        next_temp_active = 1'b1;
                        next_temp_timer = 24'(TEMP_CYCLES - 1);
                    end else begin
                        next_temp_active = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_guard <= `GUARD_RESET;
            dev_guard <= `GUARD_RESET;
            reg_unlock_val <= 1'b0;
            dev_unlock_val <= 1'b0;
            reg_unlocked <= 1'b0;
            dev_unlocked <= 1'b0;
            data_link_ctrl0 <= `DATA_LINK_CTRL0_RESET;
            loop_cfg <= `LOOP_CFG_RESET;
            saved_cfg <= `LOOP_CFG_RESET;
            temp_active <= 1'b0;
            temp_timer <= 24'h000000;
        end else begin
            reg_guard <= next_reg_guard;
            dev_guard <= next_dev_guard;
            reg_unlock_val <= next_reg_unlock_val;
            dev_unlock_val <= next_dev_unlock_val;
            reg_unlocked <= next_reg_unlocked;
            dev_unlocked <= next_dev_unlocked;
            data_link_ctrl0 <= next_data_link_ctrl0;
            loop_cfg <= next_loop_cfg;
            saved_cfg <= next_saved_cfg;
            temp_active <= next_temp_active;
            temp_timer <= next_temp_timer;
        end
    end

    assign temp_active_o = temp_active;

    // ======================================================================
    // Read ports and frame handling
    logic [7:0] next_net_rdata, next_local_rdata;
    logic next_process, next_forward, next_drop, next_ignored;
    logic [47:0] next_sender;

    always_comb begin
        next_net_rdata = net_rd_i ? read_byte(net_addr_i) : net_rdata_o;
        next_local_rdata = local_rd_i ? read_byte(local_addr_i) : local_rdata_o;
        // R16: local writes are dropped
        next_ignored = local_wr_i;
        next_process = frm_process_o;
        next_forward = frm_forward_o;
        next_drop = frm_drop_o;
        next_sender = frm_sender_addr_o;
        if (frm_start_i) begin
            next_process = frm_native_i;
            // R7: pass foreign frames
            next_forward = frm_native_i || !data_link_ctrl0[`FWD_RULE_BIT];
            // R8: destroy foreign frames
            next_drop = !frm_native_i && data_link_ctrl0[`FWD_RULE_BIT];
            // R9: mark sender locally administered
            next_sender = frm_sender_addr_i | `MAC_LOCAL_MASK;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            net_rdata_o <= 8'h00;
            local_rdata_o <= 8'h00;
            local_wr_ignored_o <= 1'b0;
            frm_process_o <= 1'b0;
            frm_forward_o <= 1'b0;
            frm_drop_o <= 1'b0;
            frm_sender_addr_o <= 48'h0000_0000_0000;
        end else begin
            net_rdata_o <= next_net_rdata;
            local_rdata_o <= next_local_rdata;
            local_wr_ignored_o <= next_ignored;
            frm_process_o <= next_process;
            frm_forward_o <= next_forward;
            frm_drop_o <= next_drop;
            frm_sender_addr_o <= next_sender;
        end
    end

    // ======================================================================
    // Loop ports
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        // R11: per-port loop control
        loop_port u_port (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .code_i(loop_code_t'(loop_cfg[2*i +: 2])),
            .code_written_i(accept && net_addr_i == `DATA_LINK_CTRL1_ADDR
                && loop_code_t'(net_wdata_i[2*i +: 2]) == LOOP_AUTO_CLOSE),
            .link_pin_i(link_up_i[i]),
            .busy_i(port_busy_i[i]),
            .valid_rx_i(valid_rx_i[i]),
            .loop_closed_o(loop_closed_o[i]),
            .port_enable_o(port_enable_o[i])
        );
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence unlock_write;
        accept && net_addr_i == `REG_UNLOCK_ADDR && !frm_end_i;
    endsequence
    sequence frame_close;
        frm_end_i;
    endsequence

    dev_guard_a: assert property (net_wr_i && dev_guard && !dev_unlocked // R4
        && net_addr_i != `DEV_UNLOCK_ADDR |-> !net_wr_accept_o)
        else $error("Write accepted under device guard.");
    reg_guard_a: assert property (net_wr_i && reg_guard && !reg_unlocked && in_area // R3
        && net_addr_i > `DEV_UNLOCK_ADDR |-> !net_wr_accept_o)
        else $error("Write accepted under register guard.");
    unlock_set_a: assert property (unlock_write ##1 !frame_edge |=> reg_unlocked) // R1
        else $error("Unlock byte did not open the guard.");
    frame_relock_a: assert property (frame_close |=> !reg_unlocked && !dev_unlocked) // R2
        else $error("Unlock survived the frame end.");
    foreign_drop_a: assert property (frm_start_i && !frm_native_i && data_link_ctrl0[0] // R8
        |=> frm_drop_o && !frm_forward_o)
        else $error("Foreign frame not destroyed.");
    foreign_pass_a: assert property (frm_start_i && !data_link_ctrl0[0] |=> frm_forward_o) // R7
        else $error("Foreign frame not passed.");
    sender_mark_a: assert property (frm_start_i |=> frm_sender_addr_o[1]) // R9
        else $error("Sender address bit not set.");
    local_write_a: assert property (local_wr_i && !net_wr_i && !temp_active // R16
        |=> $stable(loop_cfg) && $stable(reg_guard) && $stable(dev_guard))
        else $error("Local write changed a register.");
    temp_revert_a: assert property (temp_active && temp_timer == 24'h000000 && !net_wr_i // R10
        |=> loop_cfg == $past(saved_cfg) && !temp_active)
        else $error("Temporary loop setting did not revert.");

endmodule

`default_nettype wire

// >>> testbench/net_master.sv
`timescale 1ns/1ns
`default_nettype none

module net_master (
    input wire logic clk_i,
    output logic frm_start_o,
    output logic frm_end_o,
    output logic frm_native_o,
    output logic [47:0] frm_sender_addr_o,
    output logic net_wr_o,
    output logic net_rd_o,
    output logic [15:0] net_addr_o,
    output logic [7:0] net_wdata_o,
    input wire logic net_wr_accept_i
);
    initial begin
        {frm_start_o, frm_end_o, frm_native_o, net_wr_o, net_rd_o} = 5'h00;
        frm_sender_addr_o = 48'h0;
        net_addr_o = 16'h0;
        net_wdata_o = 8'h0;
    end

    task automatic frame(input logic last, input logic native, input logic [47:0] addr);
        @(posedge clk_i);
        #1;
        frm_start_o = ~last;
        frm_end_o = last;
        frm_native_o = native;
        frm_sender_addr_o = addr;
        @(posedge clk_i);
        #1;
        frm_start_o = 1'b0;
        frm_end_o = 1'b0;
        // Released qualifiers are inverted so a late sample cannot match by chance.
        frm_native_o = ~native;
        frm_sender_addr_o = ~addr;
    endtask

    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                          output logic acc);
        @(posedge clk_i);
        #1;
        net_wr_o = wr;
        net_rd_o = ~wr;
        net_addr_o = addr;
        net_wdata_o = data;
        // The accept answer is combinational, so it is taken mid-cycle.
        @(negedge clk_i);
        acc = net_wr_accept_i;
        @(posedge clk_i);
        #1;
        net_wr_o = 1'b0;
        net_rd_o = 1'b0;
        net_addr_o = ~addr;
        net_wdata_o = ~data;
    endtask

    task automatic unlock();
        logic acc;
        access(1'b1, 16'h0030, 8'ha5, acc);
        access(1'b1, 16'h0020, 8'h3c, acc);
    endtask
endmodule

`default_nettype wire

// >>> testbench/slave_write_guard_test.sv
`timescale 1ns/1ns
`default_nettype none

module slave_write_guard_test;
    localparam int TEMP = 20;
    localparam logic [15:0] REGS [9] = '{16'h0020, 16'h0021, 16'h0030, 16'h0031,
        16'h0100, 16'h0101, 16'h0102, 16'h0103, 16'h0200};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic frm_start_i, frm_end_i, frm_native_i, frm_process_o, frm_forward_o, frm_drop_o;
    logic [47:0] frm_sender_addr_i, frm_sender_addr_o;
    logic net_wr_i, net_rd_i, net_wr_accept_o, local_wr_ignored_o, temp_active_o;
    logic [15:0] net_addr_i;
    logic [7:0] net_wdata_i, net_rdata_o, local_rdata_o;
    logic local_rd_i = 1'b0;
    logic local_wr_i = 1'b0;
    logic [15:0] local_addr_i = 16'h0;
    logic [3:0] link_up_i = 4'hf;
    logic [3:0] port_busy_i = 4'h0;
    logic [3:0] valid_rx_i = 4'h0;
    logic [3:0] loop_closed_o, port_enable_o;
    logic [31:0] lfsr = 32'hf914;
    logic [8:0] exp_q[$];
    logic [8:0] note;
    logic rd_pend = 1'b0;
    logic rd_local = 1'b0;
    int err_count = 0;
    int compares = 0;

    always #50 clk_i = ~clk_i;

    slave_write_guard #(.NUM_PORTS(4), .TEMP_CYCLES(TEMP)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .frm_start_i(frm_start_i), .frm_end_i(frm_end_i),
        .frm_native_i(frm_native_i), .frm_sender_addr_i(frm_sender_addr_i),
        .frm_process_o(frm_process_o), .frm_forward_o(frm_forward_o), .frm_drop_o(frm_drop_o),
        .frm_sender_addr_o(frm_sender_addr_o), .net_wr_i(net_wr_i), .net_rd_i(net_rd_i),
        .net_addr_i(net_addr_i), .net_wdata_i(net_wdata_i), .net_wr_accept_o(net_wr_accept_o),
        .net_rdata_o(net_rdata_o), .local_rd_i(local_rd_i), .local_wr_i(local_wr_i),
        .local_addr_i(local_addr_i), .local_rdata_o(local_rdata_o),
        .local_wr_ignored_o(local_wr_ignored_o), .link_up_i(link_up_i),
        .port_busy_i(port_busy_i), .valid_rx_i(valid_rx_i), .loop_closed_o(loop_closed_o),
        .port_enable_o(port_enable_o), .temp_active_o(temp_active_o));

    net_master m (
        .clk_i(clk_i), .frm_start_o(frm_start_i), .frm_end_o(frm_end_i),
        .frm_native_o(frm_native_i), .frm_sender_addr_o(frm_sender_addr_i),
        .net_wr_o(net_wr_i), .net_rd_o(net_rd_i), .net_addr_o(net_addr_i),
        .net_wdata_o(net_wdata_i), .net_wr_accept_i(net_wr_accept_o));

    // ======================================================================
    // Helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic exp);
        logic acc;
        m.access(1'b1, a, d, acc);
        check(48'(acc), 48'(exp));
    endtask

    task automatic nrd(input logic [15:0] a, input logic [7:0] e);
        logic acc;
        exp_q.push_back({1'b0, e});
        m.access(1'b0, a, 8'h00, acc);
    endtask

    task automatic local_op(input logic wr, input logic [15:0] a, input logic [7:0] e);
        if (!wr) begin
            exp_q.push_back({1'b1, e});
        end
        @(posedge clk_i);
        #1;
        {local_wr_i, local_rd_i, local_addr_i} = {wr, ~wr, a};
        @(posedge clk_i);
        #1;
        {local_wr_i, local_rd_i, local_addr_i} = {2'b00, ~a};
    endtask

    always @(posedge clk_i) begin
        rd_pend <= net_rd_i | local_rd_i;
        rd_local <= local_rd_i;
    end

    // Read data lands one edge after the strobe, so it is compared mid-cycle.
    always @(negedge clk_i) begin
        if (rd_pend && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check(48'(rd_local ? local_rdata_o : net_rdata_o), 48'(note[7:0]));
            check(48'(rd_local), 48'(note[8]));
        end
    end

    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #(100 * 5000);
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end

    // ======================================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        tick(8);
        foreach (REGS[i]) begin
            nrd(REGS[i], 8'h00);
        end
        check(48'(loop_closed_o), 48'h0);
        for (int rule = 0; rule < 2; rule++) begin
            for (int nat = 0; nat < 2; nat++) begin
                lfsr = next_rand(lfsr);
                wr(16'h0100, 8'(rule), 1'b1);
                m.frame(1'b0, 1'(nat), {lfsr[15:0], ~lfsr});
                check(48'(frm_process_o), 48'(nat));
                check(48'(frm_forward_o), 48'(nat | (1 - rule)));
                check(48'(frm_drop_o), 48'((1 - nat) & rule));
                check(frm_sender_addr_o, {lfsr[15:0], ~lfsr} | 48'h2);
                m.frame(1'b1, 1'b1, 48'h0);
            end
        end
        wr(16'h0021, 8'h01, 1'b1);
        m.frame(1'b0, 1'b1, 48'h0);
        wr(16'h0100, 8'h00, 1'b0);
        wr(16'h0138, 8'h00, 1'b1);
        wr(16'h0030, 8'h00, 1'b1);
        wr(16'h0020, 8'h5a, 1'b1);
        wr(16'h0101, 8'h00, 1'b1);
        m.frame(1'b1, 1'b1, 48'h0);
        m.frame(1'b0, 1'b1, 48'h0);
        wr(16'h0100, 8'h00, 1'b0);
        nrd(16'h0100, 8'h01);
        m.unlock();
        wr(16'h0021, 8'h00, 1'b1);
        m.frame(1'b1, 1'b1, 48'h0);
        m.frame(1'b0, 1'b1, 48'h0);
        wr(16'h0100, 8'h00, 1'b1);
        wr(16'h0031, 8'h01, 1'b1);
        m.frame(1'b1, 1'b1, 48'h0);
        m.frame(1'b0, 1'b1, 48'h0);
        wr(16'h0200, 8'h00, 1'b0);
        wr(16'h0030, 8'h00, 1'b1);
        wr(16'h0200, 8'h00, 1'b1);
        m.frame(1'b1, 1'b1, 48'h0);
        m.frame(1'b0, 1'b1, 48'h0);
        wr(16'h0031, 8'h00, 1'b0);
        nrd(16'h0031, 8'h01);
        wr(16'h0030, 8'h00, 1'b1);
        wr(16'h0031, 8'h00, 1'b1);
        m.frame(1'b1, 1'b1, 48'h0);
        local_op(1'b1, 16'h0021, 8'h00);
        check(48'(local_wr_ignored_o), 48'h1);
        local_op(1'b0, 16'h0031, 8'h00);
        wr(16'h0101, 8'h4b, 1'b1);
        tick(3);
        check(48'(loop_closed_o), 48'h1);
        check(48'(port_enable_o), 48'he);
        link_up_i = 4'h1;
        tick(12);
        check(48'(loop_closed_o), 48'hd);
        link_up_i = 4'hf;
        tick(12);
        check(48'(loop_closed_o), 48'h9);
        valid_rx_i = 4'h8;
        tick(1);
        valid_rx_i = 4'h0;
        tick(3);
        check(48'(loop_closed_o), 48'h1);
        link_up_i = 4'h7;
        tick(12);
        link_up_i = 4'hf;
        tick(12);
        check(48'(loop_closed_o), 48'h9);
        wr(16'h0101, 8'h4b, 1'b1);
        tick(3);
        check(48'(loop_closed_o), 48'h1);
        port_busy_i = 4'h1;
        wr(16'h0101, 8'h4a, 1'b1);
        tick(5);
        check(48'(loop_closed_o), 48'h1);
        port_busy_i = 4'h0;
        tick(3);
        check(48'(loop_closed_o), 48'h0);
        wr(16'h0100, 8'h02, 1'b1);
        wr(16'h0101, 8'hff, 1'b1);
        tick(3);
        check(48'(temp_active_o), 48'h1);
        check(48'(loop_closed_o), 48'hf);
        tick(TEMP + 5);
        check(48'(temp_active_o), 48'h0);
        check(48'(loop_closed_o), 48'h0);
        nrd(16'h0101, 8'h4a);
        tick(2);
        check(48'(exp_q.size()), 48'h0);
        stop_test();
    end
endmodule

`default_nettype wire
